// [dv/ddrd_host.sv]
/*
 * Host model: frames command words on the link pins, most significant bit first.
 * Assumes the device takes data on the falling link clock edge.
 */
module ddrd_host (
  input  wire logic clk_in,
  output logic      sclk_out,
  output logic      frame_n_out,
  output logic      sdin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam time HALF = 80ns;
  // Link clock stands high between frames
  initial begin
    sclk_out    = 1'b1;
    frame_n_out = 1'b1;
    sdin_out    = 1'b0;
  end
  // Fewer than 24 bits makes a short frame that must be dropped
  task automatic send(input logic [23:0] word, input int nbits);
    @(negedge clk_in);
    frame_n_out = 1'b0;
    #HALF;
    for (int i = 0; i < nbits; i++) begin
      sclk_out = 1'b1;
      sdin_out = word[23 - i];
      #HALF;
      sclk_out = 1'b0;
      #HALF;
    end
    sclk_out = 1'b1;
    #HALF;
    frame_n_out = 1'b1;
    // Released data line flips rather than holding a stale copy
    sdin_out = ~sdin_out;
    #(2 * HALF);
  endtask
endmodule

// [dv/ddrd_top_asserts.sv]
/*
 * Checker: concurrent properties on the ports of the dual DAC register decoder.
 * Assumes it is bound to every ddrd_top instance, sharing its RESOLUTION.
 */
module ddrd_top_asserts #(
  parameter int RESOLUTION = 16
) (
  input wire logic                  MCLK_IN,
  input wire logic                  RST_IN,
  input wire logic                  OVERCURRENT_A_IN,
  input wire logic                  OVERCURRENT_B_IN,
  input wire logic                  OVERTEMP_IN,
  input wire logic                  SDO_OE_OUT,
  input wire ddrd_pkg::ddrd_code_t  CODE_A_OUT,
  input wire ddrd_pkg::ddrd_code_t  CODE_B_OUT,
  input wire logic                  POWER_A_OUT,
  input wire logic                  POWER_B_OUT,
  input wire logic                  REF_POWER_OUT,
  input wire logic                  CURRENT_LIMIT_A_OUT,
  input wire logic                  CURRENT_LIMIT_B_OUT,
  input wire logic                  THERMAL_SHUTDOWN_ENABLE_OUT,
  input wire logic [15:0]           POWER_STATUS_OUT
);
  import ddrd_pkg::*;
  // Low code bits that a narrow variant must never show
  localparam logic [15:0] LOW_MASK = 16'hFFFF >> RESOLUTION;
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  // Six samples cover the two-flop synchroniser, the flag and the status image
  sequence s_hot;  (THERMAL_SHUTDOWN_ENABLE_OUT && OVERTEMP_IN) [*6]; endsequence
  sequence s_cool; (!THERMAL_SHUTDOWN_ENABLE_OUT) [*6]; endsequence
  sequence s_oc_a; OVERCURRENT_A_IN [*6]; endsequence
  sequence s_oc_b; OVERCURRENT_B_IN [*6]; endsequence
  property p_status_spare; (POWER_STATUS_OUT & 16'hFD4A) == 16'h0000; endproperty
  property p_status_image;
    POWER_STATUS_OUT[0] == $past(POWER_A_OUT) && POWER_STATUS_OUT[2] == $past(POWER_B_OUT)
      && POWER_STATUS_OUT[4] == $past(REF_POWER_OUT);
  endproperty
  property p_hot; s_hot |-> POWER_STATUS_OUT[5] && !POWER_A_OUT && !POWER_B_OUT; endproperty
  property p_cool; s_cool |-> !POWER_STATUS_OUT[5]; endproperty
  property p_oc_a; s_oc_a |-> POWER_STATUS_OUT[7]; endproperty
  property p_oc_b; s_oc_b |-> POWER_STATUS_OUT[9]; endproperty
  property p_limit_a; CURRENT_LIMIT_A_OUT |-> ##[0:2] POWER_STATUS_OUT[7]; endproperty
  property p_limit_b; CURRENT_LIMIT_B_OUT |-> ##[0:2] POWER_STATUS_OUT[9]; endproperty
  property p_code_lsbs; ((CODE_A_OUT | CODE_B_OUT) & LOW_MASK) == 16'h0000; endproperty
  property p_reset_dflt;
    $fell(RST_IN) |-> !POWER_A_OUT && !POWER_B_OUT && !THERMAL_SHUTDOWN_ENABLE_OUT ##1 SDO_OE_OUT;
  endproperty
  a_status_spare: assert property (p_status_spare) else $error("status spare bits not zero");
  a_status_image: assert property (p_status_image) else $error("status image wrong");
  a_hot: assert property (p_hot) else $error("thermal trip missing");
  a_cool: assert property (p_cool) else $error("thermal flag while disabled");
  a_oc_a: assert property (p_oc_a) else $error("overcurrent A flag missing");
  a_oc_b: assert property (p_oc_b) else $error("overcurrent B flag missing");
  a_limit_a: assert property (p_limit_a) else $error("limit A without flag");
  a_limit_b: assert property (p_limit_b) else $error("limit B without flag");
  a_code_lsbs: assert property (p_code_lsbs) else $error("unused code bits set");
  a_reset_dflt: assert property (p_reset_dflt) else $error("reset defaults wrong");
endmodule

bind ddrd_top ddrd_top_asserts #(.RESOLUTION(RESOLUTION)) u_asserts (
  .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .OVERCURRENT_A_IN(OVERCURRENT_A_IN),
  .OVERCURRENT_B_IN(OVERCURRENT_B_IN), .OVERTEMP_IN(OVERTEMP_IN), .SDO_OE_OUT(SDO_OE_OUT),
  .CODE_A_OUT(CODE_A_OUT), .CODE_B_OUT(CODE_B_OUT), .POWER_A_OUT(POWER_A_OUT), .POWER_B_OUT(POWER_B_OUT),
  .REF_POWER_OUT(REF_POWER_OUT), .CURRENT_LIMIT_A_OUT(CURRENT_LIMIT_A_OUT),
  .CURRENT_LIMIT_B_OUT(CURRENT_LIMIT_B_OUT), .THERMAL_SHUTDOWN_ENABLE_OUT(THERMAL_SHUTDOWN_ENABLE_OUT),
  .POWER_STATUS_OUT(POWER_STATUS_OUT));

// [dv/ddrd_top_tb.sv]
/*
 * Self-checking bench: host model sends words, outputs are compared.
 * Assumes the 12-bit variant and drives the fault pins itself.
 */
`include "ddrd_regs.svh"
module ddrd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ddrd_pkg::*;
  localparam int          RES  = 12;
  localparam logic [15:0] MASK = 16'hFFFF << (16 - RES);
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        oc_a = 1'b0;
  logic        oc_b = 1'b0;
  logic        hot = 1'b0;
  logic        sclk, frame_n, sdin, serial_data_output, sdo_oe, pw_a, pw_b, pw_ref, lim_a, lim_b, tsd_en;
  ddrd_code_t  code_a, code_b;
  ddrd_range_t range_a, range_b;
  logic [15:0] status;
  int          err_total = 0;
  int          samples_checked = 0;
  always #5 clk = ~clk;
  ddrd_host host (.clk_in(clk), .sclk_out(sclk), .frame_n_out(frame_n), .sdin_out(sdin));
  ddrd_top #(.RESOLUTION(RES)) dut (
    .MCLK_IN(clk), .RST_IN(rst), .SCLK_IN(sclk), .FRAME_N_IN(frame_n), .SDIN_IN(sdin),
    .OVERCURRENT_A_IN(oc_a), .OVERCURRENT_B_IN(oc_b), .OVERTEMP_IN(hot), .SDO_OUT(serial_data_output),
    .SDO_OE_OUT(sdo_oe), .CODE_A_OUT(code_a), .CODE_B_OUT(code_b), .RANGE_A_OUT(range_a),
    .RANGE_B_OUT(range_b), .POWER_A_OUT(pw_a), .POWER_B_OUT(pw_b), .REF_POWER_OUT(pw_ref),
    .CURRENT_LIMIT_A_OUT(lim_a), .CURRENT_LIMIT_B_OUT(lim_b),
    .THERMAL_SHUTDOWN_ENABLE_OUT(tsd_en), .POWER_STATUS_OUT(status));
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic put(input logic [2:0] sel, input logic [2:0] ch, input logic [15:0] data);
    host.send({2'b00, sel, ch, data}, 24);
    repeat (4) @(negedge clk);
  endtask
  // Fault paths settle within a few cycles; twelve leaves margin
  task automatic settle();
    repeat (12) @(negedge clk);
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #900us;
    err_total++;
    summarize();
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk("reset_bits", 16'({pw_a, pw_b, pw_ref, tsd_en, sdo_oe, range_a, range_b}), 16'h0040);
    chk("reset_codes", code_a | code_b | status, 16'h0000);
    put(`DDRD_SEL_CODE, `DDRD_CH_A, 16'h1234);
    put(`DDRD_SEL_CODE, `DDRD_CH_B, 16'hABCD);
    chk("code_a_pending", code_a, 16'h0000);
    put(`DDRD_SEL_CONTROL, `DDRD_FN_LOAD, 16'hFFFF);
    chk("code_a", code_a, 16'h1234 & MASK);
    chk("code_b", code_b, 16'hABCD & MASK);
    put(`DDRD_SEL_CODE, `DDRD_CH_BOTH, 16'h5A5F);
    host.send({2'b10, `DDRD_SEL_CODE, `DDRD_CH_A, 16'h0F0F}, 24);
    chk("sdo_echo", 16'(serial_data_output), 16'h0001);
    host.send({2'b00, `DDRD_SEL_CODE, `DDRD_CH_B, 16'hF0F0}, 20);
    put(`DDRD_SEL_CODE, 3'h1, 16'hFFFF);
    put(`DDRD_SEL_CONTROL, `DDRD_FN_LOAD, 16'h0000);
    chk("code_a_both", code_a, 16'h5A5F & MASK);
    chk("code_b_both", code_b, 16'h5A5F & MASK);
    for (int r = 0; r < 6; r++) begin
      put(`DDRD_SEL_RANGE, `DDRD_CH_A, {13'h1FFF, 3'(r)});
      chk("range_a", 16'(range_a), 16'(r));
    end
    put(`DDRD_SEL_RANGE, `DDRD_CH_B, 16'h0001);
    chk("range_b", 16'(range_b), 16'h0001);
    put(`DDRD_SEL_CONTROL, `DDRD_FN_CLEAR, 16'h1234);
    chk("clear0_a", code_a, 16'h8000);
    chk("clear0_b", code_b, 16'h0000);
    put(`DDRD_SEL_CONTROL, `DDRD_FN_CONFIG, 16'hFFF6);
    put(`DDRD_SEL_CONTROL, `DDRD_FN_CLEAR, 16'h0000);
    chk("clear1_a", code_a, 16'h0000);
    chk("clear1_b", code_b, 16'h8000);
    put(`DDRD_SEL_CONTROL, `DDRD_FN_NOP, 16'hFFFF);
    chk("nop", {code_b[15:2], sdo_oe, tsd_en}, 16'h8002);
    put(`DDRD_SEL_CONTROL, `DDRD_FN_CONFIG, 16'hFFF9);
    chk("config", 16'({tsd_en, sdo_oe}), 16'h0002);
    put(`DDRD_SEL_POWER, `DDRD_CH_POWER, 16'hFFFF);
    chk("power_on", 16'({pw_a, pw_b, pw_ref}), 16'h0007);
    chk("status_on", status, 16'h0015);
    put(`DDRD_SEL_POWER, 3'h2, 16'h0000);
    chk("power_wrong_ch", 16'({pw_a, pw_b, pw_ref}), 16'h0007);
    oc_a = 1'b1;
    settle();
    chk("trip_a", 16'({pw_a, pw_b, lim_a}), 16'h0002);
    chk("trip_status", status, 16'h0094);
    oc_a = 1'b0;
    settle();
    put(`DDRD_SEL_POWER, `DDRD_CH_POWER, 16'h0015);
    chk("repower", status, 16'h0015);
    put(`DDRD_SEL_CONTROL, `DDRD_FN_CONFIG, 16'h000C);
    oc_a = 1'b1;
    oc_b = 1'b1;
    settle();
    chk("clamp_ab", 16'({pw_a, lim_a, pw_b, lim_b}), 16'h000F);
    chk("clamp_status", status, 16'h0295);
    oc_a = 1'b0;
    oc_b = 1'b0;
    settle();
    chk("clamp_gone", {lim_a, lim_b, status[13:0]}, 16'h0015);
    hot = 1'b1;
    settle();
    chk("hot_status", {pw_a, pw_b, status[13:0]}, 16'h0030);
    hot = 1'b0;
    settle();
    put(`DDRD_SEL_CONTROL, `DDRD_FN_CONFIG, 16'h0004);
    hot = 1'b1;
    settle();
    chk("hot_disabled", status, 16'h0010);
    hot = 1'b0;
    summarize();
  end
endmodule

// [logic/ddrd_pkg.sv]
/*
 * Types shared by the dual DAC register decoder modules.
 * Assumes nothing beyond the constants header.
 */
package ddrd_pkg;
  typedef logic [15:0] ddrd_code_t;
  typedef logic [2:0]  ddrd_range_t;
  typedef logic [23:0] ddrd_word_t;
  typedef enum logic [1:0] {DDRD_IDLE, DDRD_SHIFT, DDRD_DONE} ddrd_shift_state_e;
endpackage

// [logic/ddrd_regs.svh]
/*
 * Register selects, channel codes, control functions, field positions and
 * reset values of the dual DAC register decoder.
 * Assumes it is included by bare name from the modules and the bench; the package does not include it.
 */
`ifndef DDRD_REGS_SVH
`define DDRD_REGS_SVH

`define DDRD_WORD_BITS      24
`define DDRD_WORD_CNT_LAST  5'h17

// Command word fields
`define DDRD_RW_BIT         23
`define DDRD_ZERO_BIT       22
`define DDRD_REGSEL_MSB     21
`define DDRD_REGSEL_LSB     19
`define DDRD_CHSEL_MSB      18
`define DDRD_CHSEL_LSB      16

// Register selects
`define DDRD_SEL_CODE       3'h0
`define DDRD_SEL_RANGE      3'h1
`define DDRD_SEL_POWER      3'h2
`define DDRD_SEL_CONTROL    3'h3

// Channel selects
`define DDRD_CH_A           3'h0
`define DDRD_CH_B           3'h2
`define DDRD_CH_BOTH        3'h4
`define DDRD_CH_POWER       3'h0

// Control functions
`define DDRD_FN_NOP         3'h0
`define DDRD_FN_CONFIG      3'h1
`define DDRD_FN_CLEAR       3'h4
`define DDRD_FN_LOAD        3'h5

// Control configuration bits
`define DDRD_CFG_SDO_DIS    0
`define DDRD_CFG_CLR_SEL    1
`define DDRD_CFG_CLAMP_EN   2
`define DDRD_CFG_TSD_EN     3

// Power and fault bits (channel B sits two bits above channel A)
`define DDRD_PWR_PU_A       0
`define DDRD_PWR_REF        4
`define DDRD_PWR_THERMAL    5
`define DDRD_PWR_OC_A       7

// Range codes
`define DDRD_RANGE_FIRST_BIPOLAR 3'h3

// Reset values
`define DDRD_CODE_RESET     16'h0000
`define DDRD_RANGE_RESET    3'h0
`define DDRD_CLAMP_RESET    1'b1
`define DDRD_TSD_RESET      1'b0
`define DDRD_SDO_DIS_RESET  1'b0
`define DDRD_CLR_SEL_RESET  1'b0
`define DDRD_PU_RESET       1'b0

// Clear codes for offset-binary coding
`define DDRD_CODE_MID       16'h8000
`define DDRD_CODE_LOW       16'h0000

`endif

// [logic/ddrd_serial_rx.sv]
/*
 * Serial receiver: frames 24-bit words on the link pins, sampled by MCLK_IN.
 * Assumes the link clock is at most a quarter of the system clock rate.
 */
`include "ddrd_regs.svh"
module ddrd_serial_rx (
  input  wire logic      clk_in,
  input  wire logic      rst_in,
  input  wire logic      sclk_in,
  input  wire logic      frame_n_in,
  input  wire logic      sdin_in,
  ddrd_word_if.receiver  wbus
);
  import ddrd_pkg::*;

  logic [1:0]        sclk_sync_reg;
  logic [1:0]        frame_sync_reg;
  logic [1:0]        sdin_sync_reg;
  logic              sclk_prev_reg;
  logic [4:0]        cnt_reg;
  ddrd_word_t        shift_reg;
  ddrd_shift_state_e state_reg;
  logic              valid_reg;
  logic              fall;

  // All pins pass two flip-flops; data and clock share the same delay
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_sync_reg  <= 2'h0;
      frame_sync_reg <= 2'h3;
      sdin_sync_reg  <= 2'h0;
      sclk_prev_reg  <= 1'b0;
    end else begin
      sclk_sync_reg  <= {sclk_sync_reg[0], sclk_in};
      frame_sync_reg <= {frame_sync_reg[0], frame_n_in};
      sdin_sync_reg  <= {sdin_sync_reg[0], sdin_in};
      sclk_prev_reg  <= sclk_sync_reg[1];
    end
  end

  assign fall = sclk_prev_reg & ~sclk_sync_reg[1];

  // Bits taken MSB first on falling link clock edges
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= DDRD_IDLE;
      cnt_reg   <= 5'h00;
      shift_reg <= 24'h000000;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      case (state_reg)
        DDRD_IDLE: begin
          cnt_reg <= 5'h00;
          if (!frame_sync_reg[1]) begin
            state_reg <= DDRD_SHIFT;
          end
        end
        DDRD_SHIFT: begin
          // A frame that ends early is dropped without effect
          if (frame_sync_reg[1]) begin
            state_reg <= DDRD_IDLE;
          end else if (fall) begin
            shift_reg <= {shift_reg[22:0], sdin_sync_reg[1]};
            cnt_reg   <= cnt_reg + 5'h01;
            if (cnt_reg == `DDRD_WORD_CNT_LAST) begin
              valid_reg <= 1'b1;
              state_reg <= DDRD_DONE;
            end
          end
        end
        default: begin
          // Extra edges after the 24th are ignored until the frame closes
          if (frame_sync_reg[1]) begin
            state_reg <= DDRD_IDLE;
          end
        end
      endcase
    end
  end

  assign wbus.word    = shift_reg;
  assign wbus.valid   = valid_reg;
  assign wbus.sdo_bit = shift_reg[`DDRD_WORD_BITS-1];
endmodule

// [logic/ddrd_top.sv]
/*
 * Dual DAC register decoder: serial command words steer per-channel codes,
 * ranges, control settings and the power and fault register.
 * Assumes fault inputs come from asynchronous analog monitors.
 */
// What this block does
// - Register select 000 writes data to the addressed channel code register(s).
// - Code data is left-justified; unused low bits of narrower variants are ignored.
// - Register select 001 stores range bits 2..0 for the channel, ignores the rest.
// - Range codes 000..101 mean +5, +10, +10.8, +-5, +-10, +-10.8 volts.
// - Register select 011 uses the channel field as a control function code.
// - Function 000 is a no-operation changing no state.
// - Function 100 loads the clear code into all channels and updates outputs.
// - Function 101 moves pending input codes to the outputs.
// - Function 001 stores thermal enable, clamp enable, clear select, output disable.
// - Output disable bit set turns off the serial data output; clear by default.
// - Clamp enabled (default) keeps an overcurrent channel powered, limited at 20 mA.
// - Clamp disabled powers down a channel that detects overcurrent.
// - Thermal shutdown enable bit turns automatic thermal shutdown on; off by default.
// - Clear select 0 gives 0 V; 1 gives midscale unipolar, negative full scale bipolar.
// - Register select 010 with channel 000 reaches the power and fault register.
// - Power layout: OC B bit9, OC A bit7, bit6 zero, thermal 5, ref 4, PU B 2, PU A 0.
// - Channel code 000 is A, 010 is B, 100 is both.
// - Power-up bits enable channels, default off; host waits 10 us; trip clears them.
// - Thermal flag is read-only; overtemperature sets it and powers down both channels.
// - Overcurrent flag is set during the fault; in clamp mode it clears when gone.
`include "ddrd_regs.svh"
module ddrd_top #(
  parameter int RESOLUTION = 16
) (
  input  wire logic               MCLK_IN,
  input  wire logic               RST_IN,
  input  wire logic               SCLK_IN,
  input  wire logic               FRAME_N_IN,
  input  wire logic               SDIN_IN,
  input  wire logic               OVERCURRENT_A_IN,
  input  wire logic               OVERCURRENT_B_IN,
  input  wire logic               OVERTEMP_IN,
  output logic                    SDO_OUT,
  output logic                    SDO_OE_OUT,
  output ddrd_pkg::ddrd_code_t    CODE_A_OUT,
  output ddrd_pkg::ddrd_code_t    CODE_B_OUT,
  output ddrd_pkg::ddrd_range_t   RANGE_A_OUT,
  output ddrd_pkg::ddrd_range_t   RANGE_B_OUT,
  output logic                    POWER_A_OUT,
  output logic                    POWER_B_OUT,
  output logic                    REF_POWER_OUT,
  output logic                    CURRENT_LIMIT_A_OUT,
  output logic                    CURRENT_LIMIT_B_OUT,
  output logic                    THERMAL_SHUTDOWN_ENABLE_OUT,
  output logic [15:0]             POWER_STATUS_OUT
);
  import ddrd_pkg::*;

  localparam ddrd_code_t CODE_MASK = ddrd_code_t'(16'hFFFF << (16 - RESOLUTION));

  ddrd_word_if wbus ();

  ddrd_serial_rx u_rx (
    .clk_in     (MCLK_IN),
    .rst_in     (RST_IN),
    .sclk_in    (SCLK_IN),
    .frame_n_in (FRAME_N_IN),
    .sdin_in    (SDIN_IN),
    .wbus       (wbus.receiver)
  );

  logic [1:0]  oc_meta_reg;
  logic [1:0]  oc_sync_reg;
  logic        ot_meta_reg;
  logic        ot_sync_reg;
  logic        sdo_dis_reg;
  logic        clr_sel_reg;
  logic        clamp_en_reg;
  logic        tsd_en_reg;
  logic        ref_pu_reg;
  logic        thermal_reg;
  logic        sdo_reg;
  logic        sdo_oe_reg;
  logic [15:0] status_reg;
  logic [15:0] status_next;
  ddrd_code_t  pending_reg [2];
  ddrd_code_t  code_reg    [2];
  ddrd_range_t range_reg   [2];
  logic [1:0]  pu_reg;
  logic [1:0]  ocf_reg;
  logic [1:0]  limit_reg;

  logic [2:0]  regsel;
  logic [2:0]  chsel;
  logic [15:0] data;
  logic        wr_ok;
  logic        wr_code;
  logic        wr_range;
  logic        wr_power;
  logic        wr_config;
  logic        cmd_clear;
  logic        cmd_load;
  logic        thermal_trip;
  logic [1:0]  ch_hit;

  // Fault monitors are asynchronous to MCLK_IN
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      oc_meta_reg <= 2'h0;
      oc_sync_reg <= 2'h0;
      ot_meta_reg <= 1'b0;
      ot_sync_reg <= 1'b0;
    end else begin
      oc_meta_reg <= {OVERCURRENT_B_IN, OVERCURRENT_A_IN};
      oc_sync_reg <= oc_meta_reg;
      ot_meta_reg <= OVERTEMP_IN;
      ot_sync_reg <= ot_meta_reg;
    end
  end

  assign regsel = wbus.word[`DDRD_REGSEL_MSB:`DDRD_REGSEL_LSB];
  assign chsel  = wbus.word[`DDRD_CHSEL_MSB:`DDRD_CHSEL_LSB];
  assign data   = wbus.word[15:0];
  // Read requests carry no write; readback framing is not handled here
  assign wr_ok  = wbus.valid & ~wbus.word[`DDRD_RW_BIT];

  // Register and function decode
  always_comb begin
    wr_code   = 1'b0;
    wr_range  = 1'b0;
    wr_power  = 1'b0;
    wr_config = 1'b0;
    cmd_clear = 1'b0;
    cmd_load  = 1'b0;
    if (!wr_ok) begin
      wr_code = 1'b0;
    end else if (regsel == `DDRD_SEL_CODE) begin
      wr_code = 1'b1;
    end else if (regsel == `DDRD_SEL_RANGE) begin
      wr_range = 1'b1;
    end else if (regsel == `DDRD_SEL_POWER) begin
      wr_power = (chsel == `DDRD_CH_POWER);
    end else if (regsel == `DDRD_SEL_CONTROL) begin
      // Channel field picks the function; NOP and unknown codes do nothing
      wr_config = (chsel == `DDRD_FN_CONFIG);
      cmd_clear = (chsel == `DDRD_FN_CLEAR);
      cmd_load  = (chsel == `DDRD_FN_LOAD);
    end
  end

  // Channel decode; undefined channel codes hit nothing
  assign ch_hit[0] = (chsel == `DDRD_CH_A) | (chsel == `DDRD_CH_BOTH);
  assign ch_hit[1] = (chsel == `DDRD_CH_B) | (chsel == `DDRD_CH_BOTH);

  assign thermal_trip = tsd_en_reg & ot_sync_reg;

  // Control configuration bits; data bits 15..4 are dropped
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sdo_dis_reg  <= `DDRD_SDO_DIS_RESET;
      clr_sel_reg  <= `DDRD_CLR_SEL_RESET;
      clamp_en_reg <= `DDRD_CLAMP_RESET;
      tsd_en_reg   <= `DDRD_TSD_RESET;
    end else if (wr_config) begin
      sdo_dis_reg  <= data[`DDRD_CFG_SDO_DIS];
      clr_sel_reg  <= data[`DDRD_CFG_CLR_SEL];
      clamp_en_reg <= data[`DDRD_CFG_CLAMP_EN];
      tsd_en_reg   <= data[`DDRD_CFG_TSD_EN];
    end
  end

  // Reference power bit
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ref_pu_reg <= `DDRD_PU_RESET;
    end else if (wr_power) begin
      ref_pu_reg <= data[`DDRD_PWR_REF];
    end
  end

  // Flag follows the shutdown condition; host writes cannot touch it
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      thermal_reg <= 1'b0;
    end else begin
      thermal_reg <= thermal_trip;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic       bipolar;
      ddrd_code_t clr_code;

      assign bipolar  = (range_reg[ch] >= `DDRD_RANGE_FIRST_BIPOLAR);
      // Offset binary: mid code is 0 V bipolar, low code is negative full scale
      assign clr_code = (bipolar ^ clr_sel_reg) ? `DDRD_CODE_MID & CODE_MASK : `DDRD_CODE_LOW;

      always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          pending_reg[ch] <= `DDRD_CODE_RESET;
        end else if (cmd_clear) begin
          pending_reg[ch] <= clr_code;
        end else if (wr_code && ch_hit[ch]) begin
          pending_reg[ch] <= data & CODE_MASK;
        end
      end

      always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          code_reg[ch] <= `DDRD_CODE_RESET;
        end else if (cmd_clear) begin
          code_reg[ch] <= clr_code;
        end else if (cmd_load) begin
          code_reg[ch] <= pending_reg[ch];
        end
      end

      always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          range_reg[ch] <= `DDRD_RANGE_RESET;
        end else if (wr_range && ch_hit[ch]) begin
          range_reg[ch] <= data[2:0];
        end
      end

      // A trip beats a host power-up in the same cycle: the fault is real
      always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          pu_reg[ch] <= `DDRD_PU_RESET;
        end else if (thermal_trip) begin
          pu_reg[ch] <= 1'b0;
        end else if (!clamp_en_reg && oc_sync_reg[ch]) begin
          pu_reg[ch] <= 1'b0;
        end else if (wr_power) begin
          pu_reg[ch] <= data[`DDRD_PWR_PU_A + 2 * ch];
        end
      end

      // Without clamp the flag holds after power-down until the host re-powers
      always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          ocf_reg[ch] <= 1'b0;
        end else if (oc_sync_reg[ch]) begin
          ocf_reg[ch] <= 1'b1;
        end else if (clamp_en_reg) begin
          ocf_reg[ch] <= 1'b0;
        end else if (wr_power && data[`DDRD_PWR_PU_A + 2 * ch]) begin
          ocf_reg[ch] <= 1'b0;
        end
      end

      // Limit needs power: a powered-down channel cannot source current
      always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          limit_reg[ch] <= 1'b0;
        end else begin
          limit_reg[ch] <= clamp_en_reg & oc_sync_reg[ch] & pu_reg[ch];
        end
      end
    end
  endgenerate

  // Power and fault image; bit 6 and unused bits read zero
  always_comb begin
    status_next                          = 16'h0000;
    status_next[`DDRD_PWR_PU_A]          = pu_reg[0];
    status_next[`DDRD_PWR_PU_A + 2]      = pu_reg[1];
    status_next[`DDRD_PWR_REF]           = ref_pu_reg;
    status_next[`DDRD_PWR_THERMAL]       = thermal_reg;
    status_next[`DDRD_PWR_OC_A]          = ocf_reg[0];
    status_next[`DDRD_PWR_OC_A + 2]      = ocf_reg[1];
  end

  // Status image is registered so the port comes straight from a flop
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      status_reg <= 16'h0000;
    end else begin
      status_reg <= status_next;
    end
  end

  // Serial output echoes the receive shifter; disable lowers its enable
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sdo_reg    <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else begin
      sdo_reg    <= wbus.sdo_bit;
      sdo_oe_reg <= ~sdo_dis_reg;
    end
  end

  assign SDO_OUT                     = sdo_reg;
  assign SDO_OE_OUT                  = sdo_oe_reg;
  assign CODE_A_OUT                  = code_reg[0];
  assign CODE_B_OUT                  = code_reg[1];
  assign RANGE_A_OUT                 = range_reg[0];
  assign RANGE_B_OUT                 = range_reg[1];
  assign POWER_A_OUT                 = pu_reg[0];
  assign POWER_B_OUT                 = pu_reg[1];
  assign REF_POWER_OUT               = ref_pu_reg;
  assign CURRENT_LIMIT_A_OUT         = limit_reg[0];
  assign CURRENT_LIMIT_B_OUT         = limit_reg[1];
  assign THERMAL_SHUTDOWN_ENABLE_OUT = tsd_en_reg;
  assign POWER_STATUS_OUT            = status_reg;
endmodule

// [logic/ddrd_word_if.sv]
/*
 * Carries each received command word from the serial receiver to the decoder.
 * Assumes both ends run on the decoder's system clock.
 */
interface ddrd_word_if;
  import ddrd_pkg::*;
  ddrd_word_t word;
  logic       valid;
  logic       sdo_bit;
  modport receiver (output word, output valid, output sdo_bit);
  modport decoder  (input word, input valid, input sdo_bit);
endinterface
